// file: start_decode_pkg.sv
// Shared constants and carrier types for the transfer start decoder.
// Assumes a single bus master, a bus that is parked on that master, and a 10 MHz bus clock.
package start_decode_pkg;

  // ------------------------------------------------------------
  // Transfer type codes, bit 4 is the first (most significant) type line
  // ------------------------------------------------------------
  localparam logic [4:0] TT_WRITE_FLUSH = 5'h02;
  localparam logic [4:0] TT_WRITE_KILL = 5'h06;
  localparam logic [4:0] TT_READ = 5'h0a;
  localparam logic [4:0] TT_READ_MODIFY = 5'h0e;

  // ------------------------------------------------------------
  // Destination areas from the two top address bits
  // ------------------------------------------------------------
  localparam logic [1:0] AREA_SRAM = 2'h0;
  localparam logic [1:0] AREA_FAST_IO = 2'h1;
  localparam logic [1:0] AREA_SLOW_IO = 2'h2;
  localparam logic [1:0] AREA_FLASH = 2'h3;

  // ------------------------------------------------------------
  // Wait timer loads, three cycles of fixed overhead already removed
  // ------------------------------------------------------------
  localparam logic [3:0] WAIT_FAST_IO = 4'h1;
  localparam logic [3:0] WAIT_SLOW_IO = 4'h9;
  localparam logic [3:0] WAIT_FLASH = 4'h3;

  // ------------------------------------------------------------
  // Transfer size codes and lane counts
  // ------------------------------------------------------------
  localparam logic [2:0] SIZE_DOUBLE = 3'h0;
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_HALF = 3'h2;
  localparam logic [2:0] SIZE_THREE = 3'h3;
  localparam logic [2:0] SIZE_WORD = 3'h4;
  localparam int LANE_COUNT = 8;

  // ------------------------------------------------------------
  // Last burst SRAM beat index and reset values of the flags
  // ------------------------------------------------------------
  localparam logic [1:0] SRAM_LAST_BURST_BEAT = 2'h3;
  localparam logic FLAG_IDLE_N = 1'b1;

  // Attributes of a transfer, caught at its start strobe
  typedef struct packed {
    logic [1:0] area;
    logic [2:0] lane_addr;
    logic [2:0] size;
    logic burst_n;
  } xfer_attr_t;

  // Start flags, all active low
  typedef struct packed {
    logic claim_n;
    logic error_n;
    logic write_n;
  } start_flags_t;

endpackage

// file: transfer_type_decoder.sv
// Decodes the five-bit transfer type into accepted and write indications.
// Assumes the type lines are stable for the whole address tenure.
`timescale 1ns/1ps
`default_nettype none
module transfer_type_decoder
  import start_decode_pkg::*;
(
  input wire logic [4:0] transfer_type_code_in,
  output logic type_accepted_out,
  output logic type_is_write_n_out
);

  logic is_write;
  logic is_read;

  // ------------------------------------------------------------
  // Only four of the 32 codes are served
  // ------------------------------------------------------------
  assign is_write = (transfer_type_code_in == TT_WRITE_FLUSH) ||
                    (transfer_type_code_in == TT_WRITE_KILL); // R03
  assign is_read = (transfer_type_code_in == TT_READ) ||
                   (transfer_type_code_in == TT_READ_MODIFY); // R03
  assign type_accepted_out = is_write | is_read; // R02
  assign type_is_write_n_out = ~is_write; // R03

endmodule
`default_nettype wire

// file: byte_lane_decoder.sv
// Turns low address bits, size and burst into eight active-low write strobes.
// Assumes chip selects keep unselected devices from acting on the strobes.
`timescale 1ns/1ps
`default_nettype none
module byte_lane_decoder
  import start_decode_pkg::*;
(
  input wire logic [2:0] lane_addr_in,
  input wire logic [2:0] size_in,
  input wire logic burst_n_in,
  input wire logic write_n_in,
  output logic [LANE_COUNT-1:0] byte_write_n_out
);

  logic [3:0] lane_len;
  logic [3:0] lane_end;

  // ------------------------------------------------------------
  // Lane span from size
  // ------------------------------------------------------------
  always_comb begin
    case (size_in)
      SIZE_BYTE: lane_len = 4'h1;
      SIZE_HALF: lane_len = 4'h2;
      SIZE_THREE: lane_len = 4'h3;
      SIZE_WORD: lane_len = 4'h4;
      SIZE_DOUBLE: lane_len = 4'h8;
      default: lane_len = 4'h0;
    endcase
  end

  assign lane_end = {1'b0, lane_addr_in} + lane_len;

  // Bursts move whole doublewords, so every lane takes part
  for (genvar i = 0; i < LANE_COUNT; i++) begin : g_lane
    localparam logic [3:0] IDX = 4'(i);
    logic hit;
    assign hit = ~burst_n_in || (({1'b0, lane_addr_in} <= IDX) && (IDX < lane_end));
    assign byte_write_n_out[i] = ~(hit & ~write_n_in); // R14 R12
  end

endmodule
`default_nettype wire

// file: transfer_start_decoder.sv
// Front end and cycle sequencer of a single-master memory and I/O controller.
// Assumes one bus master on a parked split-transaction bus and fast pipelined burst SRAM.
//
// Overview of operation
// R01: Start strobe samples type, size and burst.
// R02: Only four transfer type codes are accepted.
// R03: Flush and kill write, the others read.
// R04: Unsupported transfers end with bus error terminate.
// R05: Each start raises claim or error, never both.
// R06: Claim sets on good start, holds until acknowledge.
// R07: Write flag follows decode while claim is active.
// R08: Error sets on bad start, holds until acknowledge.
// R09: Reset forces all three flags inactive high.
// R10: Master keeps type code stable through tenure.
// R11: Top two address bits pick the destination.
// R12: Low address, size, burst choose byte lanes.
// R13: Address acknowledge last, beat acknowledge per beat.
// R14: Eight active-low byte write strobes, written lanes.
// R15: SRAM select every access, enable on reads.
// R16: SRAM address load before first data cycle.
// R17: SRAM burst advance during data cycles two-four.
// R18: Flash select every access, enable on reads.
// R19: One I/O select per access, enable reads.
// R20: Grant and busy signals are never watched.
// R21: SRAM enable and load one clock after start.
// R22: Deselect cycle with load pulse after SRAM.
// R23: Claim and error exclusive, no restart before acknowledge.
`timescale 1ns/1ps
`default_nettype none
module transfer_start_decoder
  import start_decode_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic transfer_start_strobe_n_in,
  input wire logic [4:0] transfer_type_code_in,
  input wire logic [2:0] transfer_size_in,
  input wire logic transfer_burst_n_in,
  input wire logic [1:0] addr_area_in,
  input wire logic [2:0] addr_lane_in,
  output logic addr_ack_n_out,
  output logic beat_acknowledge_n_out,
  output logic bus_error_terminate_n_out,
  output logic [LANE_COUNT-1:0] byte_write_n_out,
  output logic sram_chip_enable_n_out,
  output logic sram_output_enable_n_out,
  output logic sram_addr_load_n_out,
  output logic sram_burst_advance_n_out,
  output logic flash_chip_select_n_out,
  output logic flash_output_enable_n_out,
  output logic [1:0] io_chip_select_n_out,
  output logic io_output_enable_n_out,
  output logic cycle_claimed_n_out,
  output logic cycle_error_n_out,
  output logic cycle_write_n_out
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SRAM_BEAT,
    ST_SRAM_DESELECT,
    ST_SLOW_WAIT,
    ST_SLOW_DONE,
    ST_ERROR_END
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  start_flags_t flags_q;
  xfer_attr_t attr_q;
  logic [1:0] beat_q;
  logic [1:0] beat_d;
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic type_accepted;
  logic type_is_write_n;
  logic addr_ack;
  logic start_ok;
  logic claim_set;
  logic claim_hold;
  logic error_set;
  logic error_hold;
  logic claimed;
  logic in_sram;
  logic is_read;
  logic sram_last_beat;
  logic [3:0] wait_load;

  // ------------------------------------------------------------
  // Type decode
  // ------------------------------------------------------------
  transfer_type_decoder u_type_dec (
    .transfer_type_code_in(transfer_type_code_in),
    .type_accepted_out(type_accepted),
    .type_is_write_n_out(type_is_write_n)
  );

  // ------------------------------------------------------------
  // Start detection
  // ------------------------------------------------------------
  // No grant or busy inputs exist: the bus is parked on the one master
  // and a start strobe alone opens a cycle.
  // A start that lands while a cycle is still open is ignored; it would
  // otherwise let claim and error overlap.
  assign start_ok = ~transfer_start_strobe_n_in & // R01 R20
                    ~(claim_hold | error_hold); // R23
  assign claim_hold = ~flags_q.claim_n & ~addr_ack; // R06
  assign error_hold = ~flags_q.error_n & ~addr_ack; // R08
  assign claim_set = (start_ok & type_accepted) | claim_hold; // R06 R05
  assign error_set = (start_ok & ~type_accepted) | error_hold; // R08 R05

  // One process owns the whole flag word, so it has a single driver
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q.claim_n <= FLAG_IDLE_N; // R09
      flags_q.write_n <= FLAG_IDLE_N; // R09
      flags_q.error_n <= FLAG_IDLE_N; // R09
    end else begin
      if (claim_set) begin
        flags_q.claim_n <= 1'b0;
        // Reloaded every held cycle; safe only because the type code
        // does not move during the address tenure.
        flags_q.write_n <= type_is_write_n; // R07 R10
      end else begin
        flags_q.claim_n <= 1'b1;
        flags_q.write_n <= 1'b1; // R07
      end
      flags_q.error_n <= ~error_set; // R08 R04
    end
  end

  // ------------------------------------------------------------
  // Transfer attributes caught at the start strobe
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      attr_q <= '0;
    end else if (start_ok) begin
      attr_q.area <= addr_area_in; // R11 R01
      attr_q.lane_addr <= addr_lane_in; // R12 R01
      attr_q.size <= transfer_size_in; // R01
      attr_q.burst_n <= transfer_burst_n_in; // R01
    end
  end

  assign claimed = ~flags_q.claim_n;
  assign is_read = flags_q.write_n;
  // A cycle claimed during the deselect must not enable the SRAM then
  assign in_sram = claimed && (attr_q.area == AREA_SRAM) && (state_q != ST_SRAM_DESELECT); // R22

  // ------------------------------------------------------------
  // Byte lanes
  // ------------------------------------------------------------
  // Strobes follow the write flag only; the chip selects keep
  // unaddressed devices from acting on them.
  byte_lane_decoder u_lane_dec (
    .lane_addr_in(attr_q.lane_addr),
    .size_in(attr_q.size),
    .burst_n_in(attr_q.burst_n),
    .write_n_in(flags_q.write_n),
    .byte_write_n_out(byte_write_n_out)
  );

  // ------------------------------------------------------------
  // Chip selects and output enables
  // ------------------------------------------------------------
  always_comb begin
    sram_chip_enable_n_out = ~in_sram; // R15 R21
    sram_output_enable_n_out = ~(in_sram & is_read); // R15
    flash_chip_select_n_out = ~(claimed && (attr_q.area == AREA_FLASH)); // R18 R11
    flash_output_enable_n_out = ~(claimed && (attr_q.area == AREA_FLASH) && is_read); // R18
    io_chip_select_n_out[0] = ~(claimed && (attr_q.area == AREA_FAST_IO)); // R19 R11
    io_chip_select_n_out[1] = ~(claimed && (attr_q.area == AREA_SLOW_IO)); // R19 R11
    io_output_enable_n_out = ~(claimed && is_read &&
                               ((attr_q.area == AREA_FAST_IO) || (attr_q.area == AREA_SLOW_IO))); // R19
  end

  // ------------------------------------------------------------
  // Wait timer load per area
  // ------------------------------------------------------------
  always_comb begin
    case (attr_q.area)
      AREA_FAST_IO: wait_load = WAIT_FAST_IO;
      AREA_SLOW_IO: wait_load = WAIT_SLOW_IO;
      AREA_FLASH: wait_load = WAIT_FLASH;
      default: wait_load = 4'h0;
    endcase
  end

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  // Flash and I/O never burst; a burst request to them still ends
  // after one beat, which the master must not issue.
  assign sram_last_beat = attr_q.burst_n || (beat_q == SRAM_LAST_BURST_BEAT);

  always_comb begin
    state_d = state_q;
    beat_d = beat_q;
    wait_d = wait_q;
    case (state_q)
      ST_IDLE: begin
        beat_d = 2'h0;
        if (!flags_q.error_n) begin
          state_d = ST_ERROR_END; // R04
        end else if (in_sram) begin
          state_d = ST_SRAM_BEAT; // R16
        end else if (claimed) begin
          wait_d = wait_load;
          state_d = ST_SLOW_WAIT;
        end
      end
      ST_SRAM_BEAT: begin
        if (sram_last_beat) begin
          state_d = ST_SRAM_DESELECT; // R22
        end else begin
          beat_d = beat_q + 2'h1;
        end
      end
      ST_SRAM_DESELECT: begin
        state_d = ST_IDLE;
      end
      ST_SLOW_WAIT: begin
        if (wait_q == 4'h0) begin
          state_d = ST_SLOW_DONE;
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      ST_SLOW_DONE: begin
        state_d = ST_IDLE;
      end
      ST_ERROR_END: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      beat_q <= 2'h0;
      wait_q <= 4'h0;
    end else begin
      beat_q <= beat_d;
      wait_q <= wait_d;
    end
  end

  // ------------------------------------------------------------
  // Bus handshakes and SRAM strobes
  // ------------------------------------------------------------
  always_comb begin
    addr_ack = 1'b0;
    beat_acknowledge_n_out = 1'b1;
    bus_error_terminate_n_out = 1'b1;
    sram_burst_advance_n_out = 1'b1;
    sram_addr_load_n_out = 1'b1;
    case (state_q)
      ST_IDLE: begin
        sram_addr_load_n_out = ~(in_sram & flags_q.error_n); // R16 R21
      end
      ST_SRAM_BEAT: begin
        beat_acknowledge_n_out = 1'b0; // R13
        addr_ack = sram_last_beat; // R13
        sram_burst_advance_n_out = ~(~attr_q.burst_n && (beat_q != 2'h0)); // R17
      end
      ST_SRAM_DESELECT: begin
        // Writes cannot be stopped by the output enable, so the SRAM
        // is told to stop by a load with its enable off.
        sram_addr_load_n_out = 1'b0; // R22
      end
      ST_SLOW_DONE: begin
        beat_acknowledge_n_out = 1'b0; // R13
        addr_ack = 1'b1; // R13
      end
      ST_ERROR_END: begin
        bus_error_terminate_n_out = 1'b0; // R04
        addr_ack = 1'b1;
      end
      default: begin
        addr_ack = 1'b0;
      end
    endcase
  end

  assign addr_ack_n_out = ~addr_ack;

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  assign cycle_claimed_n_out = flags_q.claim_n;
  assign cycle_error_n_out = flags_q.error_n;
  assign cycle_write_n_out = flags_q.write_n;

endmodule
`default_nettype wire

// file: cpu_bus_model.sv
// Bus master model: issues one address tenure at a time.
// Assumes the bench waits for the acknowledge before the next call.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic sys_clk_in,
  input wire logic addr_ack_n_in,
  output logic start_n_out,
  output logic [4:0] type_out,
  output logic [2:0] size_out,
  output logic burst_n_out,
  output logic [1:0] area_out,
  output logic [2:0] lane_out
);
  logic rel_q = 1'b0;

  initial begin
    start_n_out = 1'b1;
    {type_out, size_out, burst_n_out, area_out, lane_out} = 14'h0;
  end

  // Attributes stay put through the whole tenure
  task automatic issue(input logic [4:0] t, input logic [2:0] s, input logic b, input logic [1:0] a,
                       input logic [2:0] l);
    @(negedge sys_clk_in);
    {type_out, size_out, burst_n_out, area_out, lane_out} = {t, s, b, a, l};
    start_n_out = 1'b0;
    @(negedge sys_clk_in);
    start_n_out = 1'b1;
  endtask

  // Once acknowledged the lines are no longer held, so show garbage
  always @(posedge sys_clk_in) begin
    rel_q <= (addr_ack_n_in === 1'b0);
  end

  always @(negedge sys_clk_in) begin
    if (rel_q) begin
      {type_out, size_out, burst_n_out, area_out, lane_out} <= ~{type_out, size_out, burst_n_out, area_out, lane_out};
    end
  end
endmodule
`default_nettype wire

// file: start_decode_sva.sv
// Checker for the transfer start decoder, bound to its ports.
// Assumes one bus master that never restarts inside an error cycle.
`timescale 1ns/1ps
`default_nettype none
module start_decode_sva
  import start_decode_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic transfer_start_strobe_n_in,
  input wire logic [4:0] transfer_type_code_in,
  input wire logic transfer_burst_n_in,
  input wire logic [1:0] addr_area_in,
  input wire logic addr_ack_n_out,
  input wire logic beat_acknowledge_n_out,
  input wire logic bus_error_terminate_n_out,
  input wire logic [LANE_COUNT-1:0] byte_write_n_out,
  input wire logic sram_chip_enable_n_out,
  input wire logic sram_output_enable_n_out,
  input wire logic sram_addr_load_n_out,
  input wire logic sram_burst_advance_n_out,
  input wire logic flash_chip_select_n_out,
  input wire logic flash_output_enable_n_out,
  input wire logic cycle_claimed_n_out,
  input wire logic cycle_error_n_out,
  input wire logic cycle_write_n_out
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Starts during an SRAM close or deselect are deferred, so left out
  wire free = (cycle_claimed_n_out && cycle_error_n_out && sram_addr_load_n_out) ||
              (!addr_ack_n_out && sram_chip_enable_n_out);
  wire good = transfer_type_code_in inside {TT_WRITE_FLUSH, TT_WRITE_KILL, TT_READ, TT_READ_MODIFY};
  sequence s_take_good;
    !transfer_start_strobe_n_in && good && free;
  endsequence
  sequence s_take_bad;
    !transfer_start_strobe_n_in && !good && free;
  endsequence
  sequence s_burst_beats;
    !sram_addr_load_n_out && !sram_chip_enable_n_out ##1 sram_burst_advance_n_out && !beat_acknowledge_n_out
    ##1 (!sram_burst_advance_n_out && !beat_acknowledge_n_out)[*3] ##0 !addr_ack_n_out;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_claim_set: assert property (s_take_good |=> !cycle_claimed_n_out && cycle_error_n_out)
    else $error("claim flag not raised on accepted start");
  a_write_load: assert property (s_take_good |=> cycle_write_n_out == $past(transfer_type_code_in[3]))
    else $error("write flag wrong after accepted start");
  a_error_set: assert property (s_take_bad |=> !cycle_error_n_out && cycle_claimed_n_out)
    else $error("error flag not raised on unsupported start");
  a_flags_apart: assert property (cycle_claimed_n_out || cycle_error_n_out)
    else $error("claim and error flags both active");
  a_claim_hold: assert property (!cycle_claimed_n_out && addr_ack_n_out |=> !cycle_claimed_n_out)
    else $error("claim dropped before acknowledge");
  a_claim_drop: assert property (!cycle_claimed_n_out && !addr_ack_n_out && transfer_start_strobe_n_in
    |=> cycle_claimed_n_out && cycle_write_n_out)
    else $error("claim or write flag kept after acknowledge");
  a_error_end: assert property ($fell(cycle_error_n_out)
    |=> !bus_error_terminate_n_out && !addr_ack_n_out ##1 cycle_error_n_out)
    else $error("error cycle not terminated next cycle");
  a_tea_cause: assert property (!bus_error_terminate_n_out |-> !cycle_error_n_out)
    else $error("error terminate without error flag");
  a_sram_read: assert property (!sram_output_enable_n_out
    |-> !sram_chip_enable_n_out && cycle_write_n_out && !cycle_claimed_n_out)
    else $error("SRAM output enable outside SRAM read");
  a_flash_read: assert property (!flash_output_enable_n_out |-> !flash_chip_select_n_out && cycle_write_n_out)
    else $error("flash output enable outside flash read");
  a_burst_order: assert property (s_take_good ##0 (addr_area_in == AREA_SRAM && !transfer_burst_n_in)
    |=> s_burst_beats)
    else $error("SRAM burst load or advance out of order");
  a_sram_deselect: assert property (!cycle_claimed_n_out && !addr_ack_n_out && !sram_chip_enable_n_out
    |=> !sram_addr_load_n_out && sram_chip_enable_n_out)
    else $error("no deselect cycle after SRAM access");
  a_strobe_write: assert property (byte_write_n_out != 8'hff |-> !cycle_write_n_out)
    else $error("byte strobe on a non-write cycle");
  a_reset_idle: assert property ($fell(rst_in) |-> cycle_claimed_n_out && cycle_error_n_out && cycle_write_n_out)
    else $error("flags not idle after reset");
endmodule

bind transfer_start_decoder start_decode_sva start_decode_sva_i (.sys_clk_in, .rst_in,
  .transfer_start_strobe_n_in, .transfer_type_code_in, .transfer_burst_n_in, .addr_area_in, .addr_ack_n_out,
  .beat_acknowledge_n_out, .bus_error_terminate_n_out, .byte_write_n_out, .sram_chip_enable_n_out,
  .sram_output_enable_n_out, .sram_addr_load_n_out, .sram_burst_advance_n_out, .flash_chip_select_n_out,
  .flash_output_enable_n_out, .cycle_claimed_n_out, .cycle_error_n_out, .cycle_write_n_out);
`default_nettype wire

// file: test_transfer_start_decoder.sv
// Self-checking bench for the transfer start decoder.
// Assumes the bus model in cpu_bus_model.sv and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_transfer_start_decoder;
  import start_decode_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic transfer_start_strobe_n_in, transfer_burst_n_in;
  logic [4:0] transfer_type_code_in;
  logic [2:0] transfer_size_in, addr_lane_in;
  logic [1:0] addr_area_in, io_chip_select_n_out;
  logic addr_ack_n_out, beat_acknowledge_n_out, bus_error_terminate_n_out;
  logic [LANE_COUNT-1:0] byte_write_n_out;
  logic sram_chip_enable_n_out, sram_output_enable_n_out, sram_addr_load_n_out, sram_burst_advance_n_out;
  logic flash_chip_select_n_out, flash_output_enable_n_out, io_output_enable_n_out;
  logic cycle_claimed_n_out, cycle_error_n_out, cycle_write_n_out;
  int fail_count = 0;
  int checks_done = 0;

  always #50 sys_clk_in = ~sys_clk_in;

  cpu_bus_model cpu_bus_model_i (.sys_clk_in, .addr_ack_n_in(addr_ack_n_out),
    .start_n_out(transfer_start_strobe_n_in), .type_out(transfer_type_code_in), .size_out(transfer_size_in),
    .burst_n_out(transfer_burst_n_in), .area_out(addr_area_in), .lane_out(addr_lane_in));

  transfer_start_decoder transfer_start_decoder_i (.sys_clk_in, .rst_in, .transfer_start_strobe_n_in,
    .transfer_type_code_in, .transfer_size_in, .transfer_burst_n_in, .addr_area_in, .addr_lane_in,
    .addr_ack_n_out, .beat_acknowledge_n_out, .bus_error_terminate_n_out, .byte_write_n_out,
    .sram_chip_enable_n_out, .sram_output_enable_n_out, .sram_addr_load_n_out, .sram_burst_advance_n_out,
    .flash_chip_select_n_out, .flash_output_enable_n_out, .io_chip_select_n_out, .io_output_enable_n_out,
    .cycle_claimed_n_out, .cycle_error_n_out, .cycle_write_n_out);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One whole tenure; flags and selects are looked at in its first cycle
  task automatic run(input logic [4:0] t, input logic [2:0] s, input logic b, input logic [1:0] a,
                     input logic [2:0] l);
    logic acc, wr;
    logic [7:0] e, m;
    int n, ta, te, ack_at, len, ad, ld;
    int csb[4];
    int oeb[4];
    csb = '{6, 1, 2, 4};
    oeb = '{5, 0, 0, 3};
    acc = t inside {TT_WRITE_FLUSH, TT_WRITE_KILL, TT_READ, TT_READ_MODIFY};
    wr = acc && !t[3];
    ack_at = !acc ? 2 : (a == AREA_SRAM) ? (b ? 2 : 5) : (a == AREA_FAST_IO) ? 4 : (a == AREA_FLASH) ? 6 : 12;
    len = (s == SIZE_DOUBLE) ? 8 : int'(s);
    m = !b ? 8'hff : 8'(((16'h1 << len) - 16'h1) << l);
    e = 8'hff;
    if (acc) e[csb[a]] = 1'b0;
    if (acc && !wr) e[oeb[a]] = 1'b0;
    cpu_bus_model_i.issue(t, s, b, a, l);
    n = 1;
    ta = 0;
    te = 0;
    ad = 0;
    ld = 0;
    chk({6'h0, cycle_claimed_n_out, cycle_error_n_out}, {6'h0, !acc, acc}, "flags");
    chk({7'h0, cycle_write_n_out}, {7'h0, !wr}, "write flag");
    chk(byte_write_n_out, wr ? ~m : 8'hff, "byte strobes");
    chk({1'b1, sram_chip_enable_n_out, sram_output_enable_n_out, flash_chip_select_n_out, flash_output_enable_n_out,
         io_chip_select_n_out, io_output_enable_n_out}, e, "selects");
    do begin
      ta += (beat_acknowledge_n_out === 1'b0);
      te += (bus_error_terminate_n_out === 1'b0);
      ad += (sram_burst_advance_n_out === 1'b0);
      ld += (sram_addr_load_n_out === 1'b0);
      if (addr_ack_n_out === 1'b0) break;
      @(negedge sys_clk_in);
      n++;
    end while (n < 40);
    chk(8'(n), 8'(ack_at), "ack cycle");
    chk(8'(ta), 8'(!acc ? 0 : (!b && a == AREA_SRAM) ? 4 : 1), "beats");
    chk(8'(te), 8'(!acc), "error terminate");
    chk(8'(ad), 8'((acc && !b && a == AREA_SRAM) ? 3 : 0), "burst advance");
    chk(8'(ld), 8'(acc && a == AREA_SRAM), "address load");
    @(negedge sys_clk_in);
    chk({6'h0, sram_addr_load_n_out, sram_chip_enable_n_out}, {6'h0, !(acc && a == AREA_SRAM), 1'b1}, "deselect");
    @(negedge sys_clk_in);
    chk({6'h0, cycle_claimed_n_out, cycle_error_n_out}, 8'h03, "flags after ack");
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 32; i++) run(5'(i), SIZE_WORD, 1'b1, AREA_SRAM, 3'h0);
    run(TT_READ, SIZE_DOUBLE, 1'b0, AREA_SRAM, 3'h0);
    run(TT_WRITE_KILL, SIZE_DOUBLE, 1'b0, AREA_SRAM, 3'h0);
    run(TT_WRITE_FLUSH, SIZE_HALF, 1'b1, AREA_FLASH, 3'h0);
    run(TT_READ_MODIFY, SIZE_BYTE, 1'b1, AREA_FLASH, 3'h3);
    run(TT_READ, SIZE_BYTE, 1'b1, AREA_FAST_IO, 3'h2);
    run(TT_WRITE_FLUSH, SIZE_BYTE, 1'b1, AREA_SLOW_IO, 3'h7);
    run(TT_WRITE_FLUSH, SIZE_THREE, 1'b1, AREA_SRAM, 3'h5);
    // Reset in mid-cycle must clear the flags without a clock edge
    cpu_bus_model_i.issue(TT_WRITE_FLUSH, SIZE_WORD, 1'b1, AREA_FLASH, 3'h0);
    rst_in = 1'b1;
    #1;
    chk({5'h0, cycle_claimed_n_out, cycle_error_n_out, cycle_write_n_out}, 8'h07, "flags in reset");
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    run(TT_READ, SIZE_WORD, 1'b1, AREA_SRAM, 3'h4);
    close_out;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    fail_count++;
    close_out;
  end
endmodule
`default_nettype wire
